/* File: logic/rcsr_consts.vh */
// Constants for the second control and status register of the clock
`ifndef RCSR_CONSTS_VH
`define RCSR_CONSTS_VH

// ==========================================================
// Register address and serial command layout
`define RCSR_ADDR_CS2 4'hF
`define RCSR_MODE_WR 4'h8
`define RCSR_MODE_RD 4'hC
`define RCSR_BITS_CMD 5'h08
`define RCSR_BITS_ALL 5'h10

// ==========================================================
// Bit positions in control_status_two
`define RCSR_B_THR 7
`define RCSR_B_LOW 6
`define RCSR_B_SP1 5
`define RCSR_B_HALT 4
`define RCSR_B_CKD 3
`define RCSR_B_PER 2
`define RCSR_B_WAL 1
`define RCSR_B_DAL 0
`define RCSR_RESET_VAL 8'h10

// ==========================================================
// Periodic select encodings
`define RCSR_PER_OFF 3'h0
`define RCSR_PER_LOW 3'h1
`define RCSR_PER_2HZ 3'h2
`define RCSR_PER_1HZ 3'h3

// ==========================================================
// Alarm flag delay after a match
`define RCSR_CLK_NS 40
`define RCSR_ALARM_DLY_NS 61000
// 61 us at 40 ns per cycle, sized to the countdown register
`define RCSR_ALARM_DLY_CYC 11'h5F5
`define RCSR_DLY_W 11

`endif

/* File: logic/rcsr_top.v */
// Second control and status register with serial port and interrupt logic
`timescale 1ns/1ps
// ==========================================================
`include "rcsr_consts.vh"

module rcsr_top #(
  parameter CLKOUT_FIXED = 0
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Four-wire serial port
  input wire ser_ce,
  input wire ser_sclk,
  input wire ser_si,
  output wire ser_so,
  output wire ser_so_oe_n,
  // Analog detectors
  input wire supply_below_210,
  input wire supply_below_160,
  input wire osc_halt_detect,
  input wire xtal_clk,
  // Control register one and timekeeping
  input wire weekly_alarm_enable,
  input wire daily_alarm_enable,
  input wire clkout_disable_b,
  input wire [2:0] periodic_sel,
  input wire periodic_wave,
  input wire periodic_event,
  input wire weekly_match,
  input wire daily_match,
  // Interrupt, clock output and side effects
  output wire irq_out_n,
  output wire irq_out_oe_n,
  output wire clock_out_pin,
  output wire clock_out_oe_n,
  output wire halt_clear,
  output wire supply_mon_en,
  output wire halt_sense_en
);

  // ========================================================
  // One-hot serial states
  localparam ST_CMD = 3'b001;
  localparam ST_DATA = 3'b010;
  localparam ST_DONE = 3'b100;

  // Assemble the register image for readback
  function [7:0] rcsr_image;
    input thr, low, sp1, halt, ckd, per, wal, dal;
    begin
      rcsr_image = {thr, low, sp1, halt, ckd, per, wal, dal};
    end
  endfunction

  // ========================================================
  // Input synchronisers
  reg [1:0] ce_s_reg, sclk_s_reg, si_s_reg;
  reg [1:0] b210_s_reg, b160_s_reg, halt_s_reg, xtal_s_reg;
  reg sclk_d_reg;

  // Two flops for each serial, detector and crystal pin, first stage feeds only the second
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ce_s_reg <= 2'h0;
      sclk_s_reg <= 2'h0;
      si_s_reg <= 2'h0;
      b210_s_reg <= 2'h0;
      b160_s_reg <= 2'h0;
      halt_s_reg <= 2'h0;
      xtal_s_reg <= 2'h0;
      sclk_d_reg <= 1'b0;
    end else begin
      ce_s_reg <= {ce_s_reg[0], ser_ce};
      sclk_s_reg <= {sclk_s_reg[0], ser_sclk};
      si_s_reg <= {si_s_reg[0], ser_si};
      b210_s_reg <= {b210_s_reg[0], supply_below_210};
      b160_s_reg <= {b160_s_reg[0], supply_below_160};
      halt_s_reg <= {halt_s_reg[0], osc_halt_detect};
      xtal_s_reg <= {xtal_s_reg[0], xtal_clk};
      sclk_d_reg <= sclk_s_reg[1];
    end
  end

  wire ce_on = ce_s_reg[1];
  wire sclk_rise = sclk_s_reg[1] & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s_reg[1] & sclk_d_reg;

  // ========================================================
  // Register bits
  reg supply_threshold_select_reg;
  reg supply_low_flag_reg;
  reg spare_bit_one_reg;
  reg osc_halt_flag_reg;
  reg clkout_disable_a_reg;
  reg periodic_irq_flag_reg;
  reg level_pend_reg;
  wire [1:0] al_flag;

  wire [7:0] cs2_value = rcsr_image(supply_threshold_select_reg,
    supply_low_flag_reg, spare_bit_one_reg, osc_halt_flag_reg,
    clkout_disable_a_reg, periodic_irq_flag_reg, al_flag[1],
    al_flag[0]);

  // ========================================================
  // Serial slave: MSB first, SI taken on rising SCLK
  reg [2:0] ser_state_reg;
  reg [4:0] bit_cnt_reg;
  reg [7:0] shift_in_reg;
  reg [7:0] shift_out_reg;
  reg rd_sel_reg;
  reg wr_sel_reg;
  reg wr_go_reg;
  reg [7:0] wr_data_reg;
  reg so_reg;
  reg so_oe_n_reg;
  wire [3:0] cmd_mode = {shift_in_reg[2:0], si_s_reg[1]};

  // Framing is reset by chip enable going low, so a cut frame never writes
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_state_reg <= ST_CMD;
      bit_cnt_reg <= 5'h00;
      shift_in_reg <= 8'h00;
      shift_out_reg <= 8'h00;
      rd_sel_reg <= 1'b0;
      wr_sel_reg <= 1'b0;
      wr_go_reg <= 1'b0;
      wr_data_reg <= 8'h00;
      so_reg <= 1'b0;
      so_oe_n_reg <= 1'b1;
    end else begin
      wr_go_reg <= 1'b0;
      if (!ce_on) begin
        ser_state_reg <= ST_CMD;
        bit_cnt_reg <= 5'h00;
        rd_sel_reg <= 1'b0;
        wr_sel_reg <= 1'b0;
        so_oe_n_reg <= 1'b1;
      end else begin
        case (ser_state_reg)
          ST_CMD: begin
            if (sclk_rise) begin
              shift_in_reg <= {shift_in_reg[6:0], si_s_reg[1]};
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == `RCSR_BITS_CMD - 5'h01) begin
                ser_state_reg <= ST_DATA;
                // Only this register answers, other addresses stay silent
                if (shift_in_reg[6:3] == `RCSR_ADDR_CS2) begin
                  rd_sel_reg <= cmd_mode == `RCSR_MODE_RD;
                  wr_sel_reg <= cmd_mode == `RCSR_MODE_WR;
                  if (cmd_mode == `RCSR_MODE_RD) begin
                    shift_out_reg <= {cs2_value[6:0], 1'b0};
                    so_reg <= cs2_value[7];
                    so_oe_n_reg <= 1'b0;
                  end
                end
              end
            end
          end
          ST_DATA: begin
            if (sclk_rise) begin
              shift_in_reg <= {shift_in_reg[6:0], si_s_reg[1]};
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              if (bit_cnt_reg == `RCSR_BITS_ALL - 5'h01) begin
                ser_state_reg <= ST_DONE;
                wr_go_reg <= wr_sel_reg;
                wr_data_reg <= {shift_in_reg[6:0], si_s_reg[1]};
              end
            end else if (sclk_fall && rd_sel_reg) begin
              so_reg <= shift_out_reg[7];
              shift_out_reg <= {shift_out_reg[6:0], 1'b0};
            end
          end
          ST_DONE: so_oe_n_reg <= 1'b1; // Later bytes wait for CE low
          default: ser_state_reg <= ST_CMD;
        endcase
      end
    end
  end

  wire wr_low_clr = wr_go_reg & ~wr_data_reg[`RCSR_B_LOW];
  wire wr_halt_clr = wr_go_reg & ~wr_data_reg[`RCSR_B_HALT];
  wire wr_per_clr = wr_go_reg & ~wr_data_reg[`RCSR_B_PER];

  // ========================================================
  // Halt detection, only sampled outside serial access
  wire halt_set = halt_s_reg[1] & ~ce_on;
  wire halt_rise = halt_set & ~osc_halt_flag_reg;

  // Halt flag is sticky; the detector setting wins over a host clear
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_halt_flag_reg <= 1'b1;
    end else if (halt_set) begin
      osc_halt_flag_reg <= 1'b1;
    end else if (wr_halt_clr) begin
      osc_halt_flag_reg <= 1'b0;
    end
  end

  // ========================================================
  // Writable bits; halt flag rising clears them all
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_threshold_select_reg <= 1'b0;
      spare_bit_one_reg <= 1'b0;
      clkout_disable_a_reg <= 1'b0;
    end else if (halt_rise) begin
      supply_threshold_select_reg <= 1'b0;
      spare_bit_one_reg <= 1'b0;
      clkout_disable_a_reg <= 1'b0;
    end else if (wr_go_reg) begin
      supply_threshold_select_reg <= wr_data_reg[`RCSR_B_THR];
      spare_bit_one_reg <= wr_data_reg[`RCSR_B_SP1];
      clkout_disable_a_reg <= wr_data_reg[`RCSR_B_CKD];
    end
  end

  // ========================================================
  // Supply monitor: trip level picked by threshold select
  wire supply_trip = supply_threshold_select_reg ? b160_s_reg[1] :
    b210_s_reg[1];

  // Monitoring suspended once the flag is set, so only a clear restarts it
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_low_flag_reg <= 1'b0;
    end else if (halt_rise) begin
      supply_low_flag_reg <= 1'b0;
    end else if (!supply_low_flag_reg && supply_trip) begin
      supply_low_flag_reg <= 1'b1;
    end else if (wr_low_clr) begin
      supply_low_flag_reg <= 1'b0;
    end
  end

  // ========================================================
  // Periodic source per select code
  wire level_mode = periodic_sel[2];
  reg per_active;

  // Pulse modes follow the wave, level modes latch each period
  always @* begin
    case (periodic_sel)
      `RCSR_PER_OFF: per_active = 1'b0;
      `RCSR_PER_LOW: per_active = 1'b1;
      `RCSR_PER_2HZ: per_active = ~periodic_wave;
      `RCSR_PER_1HZ: per_active = ~periodic_wave;
      default: per_active = level_pend_reg;
    endcase
  end

  // Level latch: a new period beats a clear in the same cycle
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_pend_reg <= 1'b0;
    end else if (halt_rise || !level_mode) begin
      level_pend_reg <= 1'b0;
    end else if (periodic_event) begin
      level_pend_reg <= 1'b1;
    end else if (wr_per_clr) begin
      level_pend_reg <= 1'b0;
    end
  end

  // ========================================================
  // Alarm flags with delay after a match
  wire [1:0] al_en = {weekly_alarm_enable, daily_alarm_enable};
  wire [1:0] al_match = {weekly_match, daily_match};
  wire [1:0] al_wclr = {2{wr_go_reg}} &
    ~wr_data_reg[`RCSR_B_WAL:`RCSR_B_DAL];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_alarm
      reg [`RCSR_DLY_W-1:0] dly_reg;
      reg flag_reg;
      // Countdown arms on an enabled match; disable drops both
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          dly_reg <= {`RCSR_DLY_W{1'b0}};
          flag_reg <= 1'b0;
        end else if (!al_en[gi] || halt_rise) begin
          dly_reg <= {`RCSR_DLY_W{1'b0}};
          flag_reg <= 1'b0;
        end else begin
          if (al_match[gi]) begin
            dly_reg <= `RCSR_ALARM_DLY_CYC;
          end else if (dly_reg != {`RCSR_DLY_W{1'b0}}) begin
            dly_reg <= dly_reg - {{(`RCSR_DLY_W-1){1'b0}}, 1'b1};
          end
          if (dly_reg == {{(`RCSR_DLY_W-1){1'b0}}, 1'b1}) begin
            flag_reg <= 1'b1;
          end else if (al_wclr[gi]) begin
            flag_reg <= 1'b0;
          end
        end
      end
      assign al_flag[gi] = flag_reg;
    end
  endgenerate

  // ========================================================
  // Pin drivers, all registered
  reg irq_oe_n_reg;
  reg ck_oe_n_reg;
  reg halt_clear_reg;
  reg mon_en_reg;
  reg sense_en_reg;
  wire ck_enable = (CLKOUT_FIXED != 0) | ~clkout_disable_a_reg |
    ~clkout_disable_b;

  // Open-drain pins only ever pull low; released means the wire floats high
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_oe_n_reg <= 1'b1;
      ck_oe_n_reg <= 1'b1;
      halt_clear_reg <= 1'b0;
      mon_en_reg <= 1'b0;
      sense_en_reg <= 1'b0;
      periodic_irq_flag_reg <= 1'b0;
    end else begin
      irq_oe_n_reg <= halt_rise | ~(per_active |
        (al_flag[1] & al_en[1]) | (al_flag[0] & al_en[0]));
      ck_oe_n_reg <= ~(ck_enable & ~xtal_s_reg[1]);
      halt_clear_reg <= halt_rise;
      mon_en_reg <= ~supply_low_flag_reg;
      sense_en_reg <= ~osc_halt_flag_reg & ~ce_on;
      // Flag mirrors whether the periodic source pulls the pin low
      periodic_irq_flag_reg <= per_active & ~halt_rise;
    end
  end

  assign ser_so = so_reg;
  assign ser_so_oe_n = so_oe_n_reg;
  assign irq_out_n = 1'b0;
  assign irq_out_oe_n = irq_oe_n_reg;
  assign clock_out_pin = 1'b0;
  assign clock_out_oe_n = ck_oe_n_reg;
  assign halt_clear = halt_clear_reg;
  assign supply_mon_en = mon_en_reg;
  assign halt_sense_en = sense_en_reg;

endmodule

/* File: verif/rcsr_chk_asserts.sv */
// Port-level assertions for the control and status register block
`timescale 1ns/1ps
// ==========================================
// Checker
module rcsr_chk (
  // Clock and reset
  input wire ref_clk, rst_b,
  // Serial port
  input wire ser_ce, ser_sclk, ser_si, ser_so, ser_so_oe_n,
  // Detectors
  input wire supply_below_210, supply_below_160, osc_halt_detect, xtal_clk,
  // Control and time inputs
  input wire weekly_alarm_enable, daily_alarm_enable, clkout_disable_b,
  input wire [2:0] periodic_sel,
  input wire periodic_wave, periodic_event, weekly_match, daily_match,
  // Outputs
  input wire irq_out_n, irq_out_oe_n, clock_out_pin, clock_out_oe_n,
  input wire halt_clear, supply_mon_en, halt_sense_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Every interrupt source off long enough to cover sync and register lag
  sequence s_quiet;
    (!weekly_alarm_enable && !daily_alarm_enable && periodic_sel == 3'h0)[*4];
  endsequence
  // Lone daily match while the pin is released
  sequence s_dmatch;
    daily_match && daily_alarm_enable && !weekly_alarm_enable &&
      periodic_sel == 3'h0 && irq_out_oe_n;
  endsequence
  sense_ce_a: assert property (ser_ce[*4] |-> !halt_sense_en)
    else $error("halt sensing during access");
  halt_pulse_a: assert property (halt_clear |=> !halt_clear)
    else $error("halt clear longer than one cycle");
  halt_disarm_a: assert property (halt_clear |=> !halt_sense_en)
    else $error("sensing armed with halt flag set");
  pins_low_a: assert property (!irq_out_n && !clock_out_pin)
    else $error("open drain value not low");
  irq_idle_a: assert property (s_quiet |-> irq_out_oe_n)
    else $error("interrupt pulled with no source");
  irq_fixed_a: assert property
    ((periodic_sel == 3'h1)[*4] |-> !irq_out_oe_n)
    else $error("fixed low mode not pulling");
  alarm_early_a: assert property (s_dmatch |=> irq_out_oe_n[*8])
    else $error("alarm flag set too early");
  clk_high_a: assert property (xtal_clk[*4] |-> clock_out_oe_n)
    else $error("clock pin pulled while crystal high");
  mon_stop_a: assert property
    ((supply_below_210 && supply_below_160)[*6] |-> !supply_mon_en)
    else $error("supply monitor still armed");
  so_idle_a: assert property ((!ser_ce)[*4] |-> ser_so_oe_n)
    else $error("data out driven while deselected");
endmodule
bind rcsr_top rcsr_chk u_rcsr_chk (.ref_clk, .rst_b, .ser_ce, .ser_sclk,
  .ser_si, .ser_so, .ser_so_oe_n, .supply_below_210, .supply_below_160,
  .osc_halt_detect, .xtal_clk, .weekly_alarm_enable, .daily_alarm_enable,
  .clkout_disable_b, .periodic_sel, .periodic_wave, .periodic_event,
  .weekly_match, .daily_match, .irq_out_n, .irq_out_oe_n, .clock_out_pin,
  .clock_out_oe_n, .halt_clear, .supply_mon_en, .halt_sense_en);

/* File: verif/rcsr_host.sv */
// Host processor model driving the four-wire serial port
`timescale 1ns/1ps
// ==========================================
// Host
module rcsr_host (
  // Clock
  input wire ref_clk,
  // Serial lines
  output reg ser_ce,
  output reg ser_sclk,
  output reg ser_si,
  input wire so_line
);
  // Idle: deselected, serial clock standing low
  initial begin
    ser_ce = 1'b0;
    ser_sclk = 1'b0;
    ser_si = 1'b0;
  end
  // One whole frame, command then data, MSB first; 320 ns clock
  task xfer(input [15:0] w, output [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      ser_ce = 1'b1;
      repeat (4) @(negedge ref_clk);
      for (i = 15; i >= 0; i = i - 1) begin
        ser_si = w[i];
        repeat (4) @(negedge ref_clk);
        ser_sclk = 1'b1;
        repeat (4) @(negedge ref_clk);
        // A data bit stands from one fall to the next: take it before ours
        if (i >= 1 && i <= 8) rd[i - 1] = so_line;
        ser_sclk = 1'b0;
      end
      repeat (4) @(negedge ref_clk);
      ser_ce = 1'b0;
      repeat (6) @(negedge ref_clk);
    end
  endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the control and status register block
`timescale 1ns/1ps
`include "rcsr_consts.vh"
// ==========================================
// Bench top
module tb_top;
  reg ref_clk = 0, rst_b = 0, supply_below_210 = 0, supply_below_160 = 0;
  reg osc_halt_detect = 0, xtal_clk = 0, weekly_alarm_enable = 0;
  reg daily_alarm_enable = 0, clkout_disable_b = 0, periodic_wave = 1;
  reg periodic_event = 0, weekly_match = 0, daily_match = 0;
  reg [2:0] periodic_sel = 0;
  reg [3:0] xc = 0;
  reg [7:0] r, d, m;
  integer n_mismatch = 0, total_checks = 0, cyc = 0, n_hc = 0;
  integer seed = 1836, i, n;
  wire ser_ce, ser_sclk, ser_si, ser_so, ser_so_oe_n, irq_out_n;
  wire irq_out_oe_n, clock_out_pin, clock_out_oe_n, halt_clear;
  wire supply_mon_en, halt_sense_en;
  // Released data line shows the inverse so a stale bit cannot pass
  wire so_line = ser_so_oe_n ? ~ser_so : ser_so;
  rcsr_host u_rcsr_host (.ref_clk, .ser_ce, .ser_sclk, .ser_si, .so_line);
  rcsr_top u_rcsr_top (.ref_clk, .rst_b, .ser_ce, .ser_sclk, .ser_si,
    .ser_so, .ser_so_oe_n, .supply_below_210, .supply_below_160,
    .osc_halt_detect, .xtal_clk, .weekly_alarm_enable, .daily_alarm_enable,
    .clkout_disable_b, .periodic_sel, .periodic_wave, .periodic_event,
    .weekly_match, .daily_match, .irq_out_n, .irq_out_oe_n, .clock_out_pin,
    .clock_out_oe_n, .halt_clear, .supply_mon_en, .halt_sense_en);
  // Clock; crystal sped up to keep the run short
  always #20 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    xc <= xc + 4'h1;
    xtal_clk <= xc[3];
  end
  // Timeout and halt clear pulse count
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (halt_clear === 1'b1) n_hc = n_hc + 1;
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chkr(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0t reg %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chkp(input got, input exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0t pin %b exp %b", $time, got, exp);
      end
    end
  endtask
  task rd;
    u_rcsr_host.xfer({`RCSR_ADDR_CS2, `RCSR_MODE_RD, 8'h00}, r);
  endtask
  // Write, update model (stored 7,5,3; others only clear), read back
  task mw(input [7:0] v);
    begin
      u_rcsr_host.xfer({`RCSR_ADDR_CS2, `RCSR_MODE_WR, v}, r);
      m = (v & 8'hA8) | (m & 8'h57 & v);
      rd;
      chkr(r, m);
    end
  endtask
  task lows(output integer k);
    begin
      k = 0;
      repeat (64) @(negedge ref_clk) if (clock_out_oe_n === 1'b0) k = k + 1;
    end
  endtask
  task wt(input integer k);
    repeat (k) @(negedge ref_clk);
  endtask
  // Main sequence
  initial begin
    wt(10);
    rst_b = 1;
    wt(4);
    rd;
    chkr(r, 8'h10);
    m = 8'h10;
    mw(8'hFF);
    clkout_disable_b = 1;
    lows(n);
    chkp(n != 0, 1'b0);
    mw(8'h80);
    lows(n);
    chkp(n != 0, 1'b1);
    // Upper level ignored with 1.6 V selected, lower one latches
    supply_below_210 = 1;
    wt(10);
    rd;
    chkr(r, m);
    supply_below_160 = 1;
    wt(10);
    supply_below_210 = 0;
    supply_below_160 = 0;
    m = 8'hC0;
    mw(8'hC0);
    mw(8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      n = $random(seed);
      d = n[7:0];
      mw(d);
    end
    // Each alarm: delay, pin, flag, clear by writing zero
    for (i = 0; i < 2; i = i + 1) begin
      daily_alarm_enable = (i == 0);
      weekly_alarm_enable = (i == 1);
      wt(4);
      daily_match = (i == 0);
      weekly_match = (i == 1);
      wt(1);
      daily_match = 0;
      weekly_match = 0;
      wt(1515);
      chkp(irq_out_oe_n, 1'b1);
      wt(20);
      chkp(irq_out_oe_n, 1'b0);
      m = m | (8'h01 << i);
      rd;
      chkr(r, m);
      mw(m & ~(8'h01 << i));
      chkp(irq_out_oe_n, 1'b1);
    end
    weekly_match = 1;
    wt(1);
    weekly_match = 0;
    wt(1540);
    weekly_alarm_enable = 0;
    wt(4);
    rd;
    chkr(r, m);
    chkp(irq_out_oe_n, 1'b1);
    // Level modes: event sets flag, zero write releases the pin
    for (i = 4; i < 8; i = i + 1) begin
      periodic_sel = i[2:0];
      wt(1);
      periodic_event = 1;
      wt(1);
      periodic_event = 0;
      wt(4);
      chkp(irq_out_oe_n, 1'b0);
      rd;
      chkr(r, m | 8'h04);
      mw(m & 8'hFB);
      chkp(irq_out_oe_n, 1'b1);
    end
    // Fixed low first, then pulse modes follow the wave, then off
    for (i = 1; i < 4; i = i + 1) begin
      periodic_sel = i[2:0];
      periodic_wave = 0;
      wt(6);
      chkp(irq_out_oe_n, 1'b0);
      periodic_wave = 1;
      wt(6);
      chkp(irq_out_oe_n, i != 1);
    end
    periodic_sel = 0;
    wt(6);
    chkp(irq_out_oe_n, 1'b1);
    // Oscillator halt with chip enable low
    mw(8'hA8);
    // A pending level interrupt must be dropped by the halt
    periodic_sel = 3'h4;
    periodic_event = 1;
    wt(1);
    periodic_event = 0;
    wt(4);
    chkp(irq_out_oe_n, 1'b0);
    n = n_hc;
    osc_halt_detect = 1;
    wt(10);
    osc_halt_detect = 0;
    chkp(n_hc == n + 1, 1'b1);
    chkp(irq_out_oe_n, 1'b1);
    periodic_sel = 3'h0;
    m = 8'h10;
    rd;
    chkr(r, m);
    lows(n);
    chkp(n != 0, 1'b1);
    mw(8'h10);
    mw(8'h00);
    report_and_stop;
  end
endmodule
